// >>> verilog/lsf_pkg.sv
// Shared constants and types for the lane status flag bank
package lsf_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int LSF_LANES = 4;

    // ------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] LSF_IDX_LANE_STATUS = 8'h16;
    localparam logic [7:0] LSF_IDX_INT_STATUS  = 8'h30;
    localparam logic [7:0] LSF_IDX_INT_MASK    = 8'h31;
    localparam logic [7:0] LSF_IDX_AUX_SEL     = 8'h32;

    // ------------------------------------------------------------
    // Field positions inside lane_status
    // ------------------------------------------------------------
    localparam int LSF_COLL_LSB = 12;
    localparam int LSF_DEC_LSB  = 8;
    localparam int LSF_PASS_LSB = 4;
    localparam int LSF_NOIN_LSB = 0;

    // Bits that latch high and clear on read
    localparam logic [15:0] LSF_LATCH_MASK = 16'hFF0F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] LSF_STATUS_RST  = 16'h00F0;
    localparam logic [15:0] LSF_INT_RST     = 16'h0000;
    localparam logic [15:0] LSF_MASK_RST    = 16'h0000;
    localparam logic [7:0]  LSF_AUX_SEL_RST = 8'h00;
    localparam logic        LSF_AUX_IDLE_LVL = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LSF_AUX_IDLE  = 2'b00,
        LSF_AUX_COMMA = 2'b01,
        LSF_AUX_NOIN  = 2'b10,
        LSF_AUX_PASS  = 2'b11
    } lsf_aux_sel_e;

    typedef enum logic [0:0] {
        LSF_BUS_IDLE   = 1'b0,
        LSF_BUS_ANSWER = 1'b1
    } lsf_bus_state_e;

    // One-cycle event pulses, laid out like lane_status
    typedef struct packed {
        logic [3:0] coll;
        logic [3:0] dec;
        logic [3:0] pat_err;
        logic [3:0] no_input;
    } lsf_events_s;

endpackage : lsf_pkg

// >>> verilog/lsf_flag_cell.sv
// One sticky flag bit that an event drives and a read undoes
`timescale 1ns/10ps
module lsf_flag_cell #(
    parameter logic SET_VAL = 1'b1,  // Value an event forces
    parameter logic RST_VAL = 1'b0   // Value after reset
) (
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic event_i,   // Event pulse
    input  wire logic clear_i,   // Read completes this cycle
    input  wire logic shown_i,   // Value the read returned
    output logic      flag_o
);

    logic flag_reg;
    logic flag_next;
    logic undo;

    // Undo only what the read really showed, so nothing is lost
    assign undo = clear_i && (shown_i == SET_VAL);

    // Event beats the undo in the same cycle
    assign flag_next = event_i ? SET_VAL :
                       undo    ? ~SET_VAL : flag_reg;

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_reg <= RST_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;

endmodule : lsf_flag_cell

// >>> verilog/lsf_top.sv
// Lane status flag bank with Avalon-MM slave and interrupt
`timescale 1ns/10ps

// Behaviour
// - collision bits 15:12 set per lane
// - sticky bits clear after being read
// - decode error bits 11:8 set per lane
// - pattern ok bits 7:4 reset to one
// - pattern error drives pattern ok low
// - read of zero pattern bit restores one
// - no-input bits 3:0 set per lane
// - collision and decode bits reset zero
// - no-input bits reset to zero
// - aux pin select 10 shows no-input
// - aux pin select 11 shows pattern ok
module lsf_top
    import lsf_pkg::*;
#(
    parameter int LANES = LSF_LANES  // Lane count
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  address_i,    // Byte address
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire lsf_events_s lane_evt_i,   // Core event pulses
    input  wire logic [3:0]  comma_det_i,  // Core comma flags
    output logic      [3:0]  aux_output_pin_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    lsf_bus_state_e state_reg;      // Bus handshake state
    lsf_bus_state_e state_next;
    logic        wait_reg;          // Drives waitrequest
    logic [31:0] rdata_reg;         // Captured read data
    logic [15:0] mask_reg;          // Interrupt mask
    logic [7:0]  aux_sel_reg;       // Two bits per lane
    logic [3:0]  aux_reg;           // Aux pin flops
    logic        irq_reg;
    logic [15:0] lane_status;       // Live flag bits
    logic [15:0] int_stat;          // Sticky interrupt bits
    logic [15:0] evt_vec;           // Events as a vector
    logic [3:0]  aux_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [7:0] adr_status = {LSF_IDX_LANE_STATUS[5:0], 2'b00};
    wire [7:0] adr_int    = {LSF_IDX_INT_STATUS[5:0], 2'b00};
    wire [7:0] adr_mask   = {LSF_IDX_INT_MASK[5:0], 2'b00};
    wire [7:0] adr_aux    = {LSF_IDX_AUX_SEL[5:0], 2'b00};

    wire hit_status = (address_i == adr_status);
    wire hit_int    = (address_i == adr_int);
    wire hit_mask   = (address_i == adr_mask);
    wire hit_aux    = (address_i == adr_aux);

    // Request seen while idle, completed in answer state
    wire req    = read_i | write_i;
    wire accept = (state_reg == LSF_BUS_ANSWER) && req;
    wire wr_acc = accept && write_i;

    // Clear-on-read strobes at the completing edge
    wire clr_status = accept && read_i && hit_status;
    wire clr_int    = accept && read_i && hit_int;

    // Unmapped addresses read zero
    wire [15:0] rd_mux = hit_status ? lane_status :
                         hit_int    ? int_stat :
                         hit_mask   ? mask_reg :
                         hit_aux    ? {8'h00, aux_sel_reg} :
                                      16'h0000;

    assign evt_vec = lane_evt_i;

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then one answer cycle
    // ------------------------------------------------------------
    assign state_next = (state_reg == LSF_BUS_ANSWER) ?
                        LSF_BUS_IDLE :
                        (req ? LSF_BUS_ANSWER : LSF_BUS_IDLE);

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= LSF_BUS_IDLE;
            wait_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            wait_reg  <= (state_next != LSF_BUS_ANSWER);
        end
    end

    // Read data captured before any clear takes effect
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                LSF_BUS_IDLE: begin
                    if (req) begin
                        rdata_reg <= {16'h0000, rd_mux};
                    end
                end
                default: begin
                    rdata_reg <= rdata_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Writable control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_reg    <= LSF_MASK_RST;
            aux_sel_reg <= LSF_AUX_SEL_RST;
        end else begin
            if (wr_acc && hit_mask && byteenable_i[0]) begin
                mask_reg[7:0] <= writedata_i[7:0];
            end
            if (wr_acc && hit_mask && byteenable_i[1]) begin
                mask_reg[15:8] <= writedata_i[15:8];
            end
            if (wr_acc && hit_aux && byteenable_i[0]) begin
                aux_sel_reg <= writedata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Flag cells: status bits and interrupt bits
    // ------------------------------------------------------------
    // Pattern bits idle at one and fall on error; all others
    // idle at zero and rise on their event.
    for (genvar b = 0; b < 16; b++) begin : g_bit
        localparam logic IS_PASS = (b >= LSF_PASS_LSB) &&
                                   (b < LSF_DEC_LSB);
        lsf_flag_cell #(
            .SET_VAL (~IS_PASS),
            .RST_VAL (LSF_STATUS_RST[b])
        ) u_stat (
            .core_clk_i (core_clk_i),
            .reset_n_i  (reset_n_i),
            .event_i    (evt_vec[b]),
            .clear_i    (clr_status),
            .shown_i    (rdata_reg[b]),
            .flag_o     (lane_status[b])
        );
        // Interrupt copy, sticky until its own register is read
        lsf_flag_cell #(
            .SET_VAL (1'b1),
            .RST_VAL (LSF_INT_RST[b])
        ) u_int (
            .core_clk_i (core_clk_i),
            .reset_n_i  (reset_n_i),
            .event_i    (evt_vec[b]),
            .clear_i    (clr_int),
            .shown_i    (rdata_reg[b]),
            .flag_o     (int_stat[b])
        );
    end

    // ------------------------------------------------------------
    // Aux output pin selection per lane
    // ------------------------------------------------------------
    for (genvar n = 0; n < LANES; n++) begin : g_aux
        wire [1:0] sel = aux_sel_reg[2*n+1 -: 2];
        assign aux_next[n] =
            (sel == LSF_AUX_NOIN)  ? lane_status[LSF_NOIN_LSB+n] :
            (sel == LSF_AUX_PASS)  ? lane_status[LSF_PASS_LSB+n] :
            (sel == LSF_AUX_COMMA) ? comma_det_i[n] :
                                     LSF_AUX_IDLE_LVL;

        AST_AUX_NOIN: assert property (
            @(posedge core_clk_i) disable iff (!reset_n_i)
            (sel == LSF_AUX_NOIN) && $stable(sel) |=>
            aux_output_pin_o[n] == $past(lane_status[LSF_NOIN_LSB+n]))
            else $error("aux pin not showing no-input flag");
        AST_AUX_PASS: assert property (
            @(posedge core_clk_i) disable iff (!reset_n_i)
            (sel == LSF_AUX_PASS) && $stable(sel) |=>
            aux_output_pin_o[n] == $past(lane_status[LSF_PASS_LSB+n]))
            else $error("aux pin not showing pattern flag");
    end

    // Pins and interrupt come from flops; one cycle behind flags
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aux_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            aux_reg <= aux_next;
            irq_reg <= |(int_stat & mask_reg);
        end
    end

    assign readdata_o       = rdata_reg;
    assign waitrequest_o    = wait_reg;
    assign aux_output_pin_o = aux_reg;
    assign irq_o            = irq_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Marks the first sampled edge after reset release
    logic first_reg;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    AST_COLL_SET: assert property (
        (|lane_evt_i.coll) |=>
        (lane_status[15:12] & $past(lane_evt_i.coll)) ==
        $past(lane_evt_i.coll))
        else $error("collision event not latched");

    AST_STICKY_CLEAR: assert property (
        clr_status && (evt_vec == 16'h0000) |=>
        (lane_status & LSF_LATCH_MASK & $past(rdata_reg[15:0]))
        == 16'h0000)
        else $error("read did not clear sticky bits");

    AST_STICKY_HOLD: assert property (
        !clr_status && (evt_vec == 16'h0000) ##1
        !clr_status && (evt_vec == 16'h0000) |=>
        (lane_status & LSF_LATCH_MASK) ==
        ($past(lane_status, 2) & LSF_LATCH_MASK))
        else $error("sticky bits changed without cause");

    AST_DEC_SET: assert property (
        (|lane_evt_i.dec) |=>
        (lane_status[11:8] & $past(lane_evt_i.dec)) ==
        $past(lane_evt_i.dec))
        else $error("decode error not latched");

    AST_PASS_HOLD: assert property (
        (lane_status[7:4] == 4'hF) &&
        (lane_evt_i.pat_err == 4'h0) |=> lane_status[7:4] == 4'hF)
        else $error("pattern ok fell without error");

    AST_PASS_DROP: assert property (
        (|lane_evt_i.pat_err) |=>
        (lane_status[7:4] & $past(lane_evt_i.pat_err)) == 4'h0)
        else $error("pattern error did not clear ok bit");

    AST_PASS_RESTORE: assert property (
        clr_status && (lane_evt_i.pat_err == 4'h0) |=>
        (lane_status[7:4] | $past(rdata_reg[7:4])) == 4'hF)
        else $error("read did not restore pattern ok");

    AST_NOIN_SET: assert property (
        (|lane_evt_i.no_input) |=>
        (lane_status[3:0] & $past(lane_evt_i.no_input)) ==
        $past(lane_evt_i.no_input))
        else $error("no-input event not latched");

    AST_RST_ERRBITS: assert property (
        first_reg |-> lane_status[15:8] == 8'h00)
        else $error("error bits not zero after reset");

    AST_RST_NOIN: assert property (
        first_reg |-> lane_status[3:0] == 4'h0 &&
        lane_status[7:4] == 4'hF)
        else $error("no-input or pattern bits wrong after reset");

    AST_EVENT_WINS: assert property (
        clr_status && (|lane_evt_i.coll) |=>
        (lane_status[15:12] & $past(lane_evt_i.coll)) ==
        $past(lane_evt_i.coll))
        else $error("event lost to clear");

    AST_ONE_WAIT: assert property (
        (state_reg == LSF_BUS_IDLE) && req |=>
        !waitrequest_o ##1 waitrequest_o)
        else $error("answer not after one wait cycle");

    AST_IRQ: assert property (
        ((int_stat & mask_reg) != 16'h0000) |=> irq_o)
        else $error("unmasked status without interrupt");

    CVR_STATUS_READ: cover property (clr_status);
    CVR_PASS_RESTORE: cover property (
        clr_status && (rdata_reg[7:4] != 4'hF));
    CVR_EVT_ON_CLEAR: cover property (clr_status && |evt_vec);
    CVR_IRQ: cover property ($rose(irq_o));

endmodule : lsf_top

// >>> tb/lsf_top_tb_top.sv
// Self-checking bench for the lane status flag bank
`timescale 1ns/10ps
module lsf_top_tb_top;
    import lsf_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        core_clk_i   = 1'b0;   // 25 MHz core clock
    logic        reset_n_i    = 1'b0;   // Held low at start
    logic [7:0]  address_i    = 8'h00;  // Byte address
    logic        read_i       = 1'b0;
    logic        write_i      = 1'b0;
    logic [31:0] writedata_i  = 32'h0000_0000;
    logic [3:0]  byteenable_i = 4'hF;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    lsf_events_s lane_evt_i   = '0;     // Event pulses from the core
    logic [3:0]  comma_det_i  = 4'h0;
    logic [3:0]  aux_output_pin_o;
    logic        irq_o;
    int          bad_count    = 0;      // Mismatches seen
    int          checks_done  = 0;      // Comparisons made
    logic [15:0] ev;                    // Event pattern in flight

    // ------------------------------------------------------------
    // Clock and design
    // ------------------------------------------------------------
    // Half period of 20 ns gives the 40 ns core period
    always #20 core_clk_i = ~core_clk_i;

    lsf_top DUT (
        .core_clk_i       (core_clk_i),
        .reset_n_i        (reset_n_i),
        .address_i        (address_i),
        .read_i           (read_i),
        .write_i          (write_i),
        .writedata_i      (writedata_i),
        .byteenable_i     (byteenable_i),
        .readdata_o       (readdata_o),
        .waitrequest_o    (waitrequest_o),
        .lane_evt_i       (lane_evt_i),
        .comma_det_i      (comma_det_i),
        .aux_output_pin_o (aux_output_pin_o),
        .irq_o            (irq_o)
    );

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    // Verdict and end of run; every path out of the bench lands here
    task automatic results;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Compare with four-state equality so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    // Wait for the completing edge; the request stays up until then.
    // Waitrequest is read just after each rising edge, before the
    // slave's flops update, so it is the level sampled at that edge.
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        if (waitrequest_o !== 1'b0) begin
            $display("Error at %0t: got %h expected %h", $time, 1, 0);
            bad_count++;
            results();
        end
    endtask : bus_wait

    // One Avalon read; a clock edge passes before the request rises
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        address_i <= a;
        read_i    <= 1'b1;
        bus_wait();
        // Data taken at the completing edge, request released there
        d = readdata_o;
        read_i    <= 1'b0;
    endtask : bus_rd

    // One Avalon write, taking effect at the completing edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        address_i   <= a;
        writedata_i <= d;
        write_i     <= 1'b1;
        bus_wait();
        write_i     <= 1'b0;
    endtask : bus_wr

    // Read a register and compare it in one step
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    // One-cycle event pulse laid out like lane_status
    task automatic pulse(input logic [15:0] v);
        @(posedge core_clk_i);
        lane_evt_i <= lsf_events_s'(v);
        @(posedge core_clk_i);
        lane_evt_i <= '0;
    endtask : pulse

    // Let registered outputs settle, then compare a pin level
    task automatic pin_chk(input logic [31:0] got_sel, input logic [3:0] e);
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk(got_sel ? {31'h0, irq_o} : {28'h0, aux_output_pin_o},
            {28'h0, e});
    endtask : pin_chk

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        // Reset values of every register and output
        rd_chk(8'h58, 32'h0000_00F0);
        rd_chk(8'hC0, 32'h0000_0000);
        rd_chk(8'hC4, 32'h0000_0000);
        rd_chk(8'hC8, 32'h0000_0000);
        pin_chk(0, 4'hF);
        pin_chk(1, 4'h0);
        // Per lane: all four kinds of event, then clear and restore
        for (int i = 0; i < 4; i++) begin
            ev = 16'h1111 << i;
            pulse(ev);
            rd_chk(8'h58, (16'h1101 << i) |
                   (16'h00F0 & ~(16'h0010 << i)));
            rd_chk(8'h58, 32'h0000_00F0);
            rd_chk(8'hC0, {16'h0, ev});
            rd_chk(8'hC0, 32'h0000_0000);
            pin_chk(1, 4'h0);
        end
        // Writes to the status register and unmapped reads do nothing
        bus_wr(8'h58, 32'h0000_FF0F);
        rd_chk(8'h58, 32'h0000_00F0);
        rd_chk(8'h00, 32'h0000_0000);
        bus_wr(8'h04, 32'h0000_FFFF);
        rd_chk(8'hC4, 32'h0000_0000);
        // Event held across the clearing edge must survive
        lane_evt_i <= lsf_events_s'(16'h0088);
        rd_chk(8'h58, 32'h0000_0078);
        rd_chk(8'h58, 32'h0000_0078);
        lane_evt_i <= '0;
        rd_chk(8'h58, 32'h0000_0078);
        rd_chk(8'h58, 32'h0000_00F0);
        rd_chk(8'hC0, 32'h0000_0088);
        // Aux pins: each select code in turn
        comma_det_i <= 4'b1001;
        bus_wr(8'hC8, 32'h0000_0055);
        rd_chk(8'hC8, 32'h0000_0055);
        pin_chk(0, 4'b1001);
        bus_wr(8'hC8, 32'h0000_00AA);
        pulse(16'h0005);
        pin_chk(0, 4'b0101);
        rd_chk(8'h58, 32'h0000_00F5);
        pin_chk(0, 4'b0000);
        bus_wr(8'hC8, 32'h0000_00FF);
        pin_chk(0, 4'b1111);
        pulse(16'h0030);
        pin_chk(0, 4'b1100);
        rd_chk(8'h58, 32'h0000_00C0);
        pin_chk(0, 4'b1111);
        bus_wr(8'hC8, 32'h0000_0000);
        pin_chk(0, 4'hF);
        rd_chk(8'hC0, 32'h0000_0035);
        // Interrupt: masked event, unmasked event, clear by read
        byteenable_i <= 4'h3;
        bus_wr(8'hC4, 32'h0000_1000);
        rd_chk(8'hC4, 32'h0000_1000);
        pulse(16'h0100);
        pin_chk(1, 4'h0);
        pulse(16'h1000);
        pin_chk(1, 4'h1);
        rd_chk(8'hC0, 32'h0000_1100);
        pin_chk(1, 4'h0);
        rd_chk(8'h58, 32'h0000_11F0);
        // Byte enables: only byte lane 0 of the mask takes the write
        byteenable_i <= 4'h1;
        bus_wr(8'hC4, 32'h0000_FFFF);
        rd_chk(8'hC4, 32'h0000_10FF);
        results();
    end

endmodule : lsf_top_tb_top
